// >>> rtl/pmsp_top.sv
// Contract
// - Converter input reaching 18V enables the step-down converter.
// - Main supply at 10V, wait 4ms, then enable system supply.
// - System supply good, wait 0.5ms, then enable IO supply.
// - 0.5ms after IO supply, enable analog supply.
// - 1ms after analog supply, enable core supply last.
// - Check all four power-good flags 0.5ms after core enable.
// - All good at check: wait 11.5ms, then release MCU reset.
// - Input undervoltage shutdown restarts at once when input rises again.
// - Input fine but main supply low: converter off, 350ms, restart.
// - Input undervoltage uses 19V rising and 17V falling thresholds.
// - A firmware register write enters hibernate, shutting regulators down.
// - Hibernate turns every internal regulator off.
// - Wake from button with polarity, pack detect, or wakeup timer.
// - Pack detect wake threshold selectable between 5V and 20V.
// - Any supply losing power good flags a fault and resets MCU.
// - MCU held in reset until all supplies good and delay expired.
// - Monitor multiplexer selects one of eight sources for the ADC.
// - Warnings at 120C and 140C do not reset the MCU.
// - Firmware enables interrupts per temperature level.
// - Reaching 155C declares a fault and resets the MCU.
// - Temperature fault status survives the reset it causes.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "pmsp_params.svh"
module pmsp_top #(
    parameter int unsigned T_VP_CYC   = `PMSP_T_VP_CYC,
    parameter int unsigned T_SYS_CYC  = `PMSP_T_SYS_CYC,
    parameter int unsigned T_IO_CYC   = `PMSP_T_IO_CYC,
    parameter int unsigned T_ANA_CYC  = `PMSP_T_ANA_CYC,
    parameter int unsigned T_CHK_CYC  = `PMSP_T_CHK_CYC,
    parameter int unsigned T_RST_CYC  = `PMSP_T_RST_CYC,
    parameter int unsigned T_BACK_CYC = `PMSP_T_BACK_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire pmsp_pkg::pmsp_apb_req_t apb_req,
    output      pmsp_pkg::pmsp_apb_rsp_t apb_rsp,
    input  wire logic [`PMSP_NS-1:0]    sense,
    output      pmsp_pkg::pmsp_rails_t  rails,
    output      logic                   mcu_rst_n,
    output      logic                   gate_drive_pump_en,
    output      pmsp_pkg::pmsp_mux_t    monitoring_multiplexer_sel,
    output      logic                   pack_thr_high,
    output      logic                   temp_irq
);

    localparam int TW = `PMSP_TMR_W;

    logic                 rst_q1;
    logic                 rst_s;
    pmsp_pkg::pmsp_regs_t r;
    pmsp_pkg::pmsp_regs_t n;
    logic                 wr;
    logic                 setup;
    logic                 all_pg;
    logic                 go_ok;
    logic                 wake_hit;
    logic                 tmr_done;
    logic                 hib_req;
    logic [3:0]           stat_clr;
    logic [3:0]           stat_set;

    // Reset release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_s  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_s  <= rst_q1;
        end
    end

    assign all_pg   = r.flt[`PMSP_S_SYS_PG] & r.flt[`PMSP_S_IO_PG]
                    & r.flt[`PMSP_S_ANA_PG] & r.flt[`PMSP_S_CORE_PG];
    assign go_ok    = all_pg & ~r.flt[`PMSP_S_T155];
    assign tmr_done = (r.tmr == '0);
    assign wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign setup    = apb_req.psel & ~apb_req.penable;
    assign hib_req  = wr && (apb_req.paddr == `PMSP_OFF_CTRL)
                    && apb_req.pwdata[`PMSP_CTRL_HIB];
    assign wake_hit = (r.wake[`PMSP_WAKE_BTN_EN]
                       && (r.flt[`PMSP_S_BUTTON] == r.wake[`PMSP_WAKE_BTN_POL]))
                    | (r.wake[`PMSP_WAKE_PACK_EN] & r.flt[`PMSP_S_PACK])
                    | (r.wake[`PMSP_WAKE_TMR_EN] & r.flt[`PMSP_S_WAKE_TMR]);
    assign stat_clr = (wr && (apb_req.paddr == `PMSP_OFF_STAT)) ? apb_req.pwdata[3:0] : 4'h0;
    assign stat_set = {(r.st == pmsp_pkg::ST_RUN) & ~all_pg,
                       r.flt[`PMSP_S_T155],
                       r.flt[`PMSP_S_T140],
                       r.flt[`PMSP_S_T120]};

    always_comb begin
        n = r;
        // Input synchroniser and debounce
        n.s1 = sense;
        n.s2 = r.s1;
        for (int i = 0; i < `PMSP_NS; i++) begin
            if (r.s2[i] == r.flt[i]) begin
                n.dc[i] = 3'h0;
            end else if (r.dc[i] == `PMSP_DEB_CYC - 3'h1) begin
                n.flt[i] = r.s2[i];
                n.dc[i]  = 3'h0;
            end else begin
                n.dc[i] = r.dc[i] + 3'h1;
            end
        end

        // Input undervoltage hysteresis
        if (!r.flt[`PMSP_S_VIN_UVF]) begin
            n.vin_ok = 1'b0;
        end else if (r.flt[`PMSP_S_VIN_UVR]) begin
            n.vin_ok = 1'b1;
        end

        // Register writes, set wins over clear
        n.stat = (r.stat & ~stat_clr) | stat_set;
        if (wr) begin
            case (apb_req.paddr)
                `PMSP_OFF_CTRL: begin
                    n.pump = apb_req.pwdata[`PMSP_CTRL_PUMP];
                    n.mux  = pmsp_pkg::pmsp_mux_t'(
                             apb_req.pwdata[`PMSP_CTRL_MUX_HI:`PMSP_CTRL_MUX_LO]);
                end
                `PMSP_OFF_WAKE:   n.wake   = apb_req.pwdata[4:0];
                `PMSP_OFF_IRQ_EN: n.irq_en = apb_req.pwdata[2:0];
                default: begin
                end
            endcase
        end

        // Read data for the access phase
        if (setup) begin
            n.pslverr = 1'b0;
            case (apb_req.paddr)
                `PMSP_OFF_CTRL:   n.prdata = {27'h0, r.mux, r.pump, 1'b0};
                `PMSP_OFF_WAKE:   n.prdata = {27'h0, r.wake};
                `PMSP_OFF_STAT:   n.prdata = {28'h0, r.stat};
                `PMSP_OFF_IRQ_EN: n.prdata = {29'h0, r.irq_en};
                `PMSP_OFF_STATE:  n.prdata = {4'h0, r.vin_ok, r.flt, r.st};
                default: begin
                    n.prdata  = 32'h0;
                    n.pslverr = 1'b1;
                end
            endcase
        end

        // Temperature interrupt
        n.irq = |(n.stat[2:0] & n.irq_en);

        // Sequencer
        if (!tmr_done) begin
            n.tmr = r.tmr - TW'(1);
        end
        case (r.st)
            pmsp_pkg::ST_OFF: begin
                if (r.flt[`PMSP_S_VIN_START]) begin
                    n.st = pmsp_pkg::ST_BUCK;
                end
            end

            pmsp_pkg::ST_BUCK: begin
                if (r.flt[`PMSP_S_VP_UVR]) begin
                    n.st      = pmsp_pkg::ST_VPW;
                    n.tmr     = TW'(T_VP_CYC);
                    n.vp_seen = 1'b1;
                end
            end

            pmsp_pkg::ST_VPW: begin
                if (tmr_done) begin
                    n.st  = pmsp_pkg::ST_SYSW;
                    n.tmr = TW'(T_SYS_CYC);
                end
            end

            pmsp_pkg::ST_SYSW: begin
                if (!r.flt[`PMSP_S_SYS_PG]) begin
                    n.tmr = TW'(T_SYS_CYC);
                end else if (tmr_done) begin
                    n.st  = pmsp_pkg::ST_IOW;
                    n.tmr = TW'(T_IO_CYC);
                end
            end

            pmsp_pkg::ST_IOW: begin
                if (tmr_done) begin
                    n.st  = pmsp_pkg::ST_ANAW;
                    n.tmr = TW'(T_ANA_CYC);
                end
            end

            pmsp_pkg::ST_ANAW: begin
                if (tmr_done) begin
                    n.st  = pmsp_pkg::ST_CHK;
                    n.tmr = TW'(T_CHK_CYC);
                end
            end

            pmsp_pkg::ST_CHK: begin
                if (tmr_done && go_ok) begin
                    n.st  = pmsp_pkg::ST_RSTD;
                    n.tmr = TW'(T_RST_CYC);
                end
            end

            pmsp_pkg::ST_RSTD: begin
                if (!go_ok) begin
                    n.st  = pmsp_pkg::ST_CHK;
                    n.tmr = '0;
                end else if (tmr_done) begin
                    n.st = pmsp_pkg::ST_RUN;
                end
            end

            pmsp_pkg::ST_RUN: begin
                if (!go_ok) begin
                    n.st  = pmsp_pkg::ST_CHK;
                    n.tmr = '0;
                end else if (hib_req) begin
                    n.st = pmsp_pkg::ST_HIB;
                end
            end

            pmsp_pkg::ST_BACK: begin
                if (tmr_done) begin
                    n.st = pmsp_pkg::ST_BUCK;
                end
            end

            pmsp_pkg::ST_UVLO: begin
                if (r.vin_ok) begin
                    n.st = pmsp_pkg::ST_BUCK;
                end
            end

            pmsp_pkg::ST_HIB: begin
                if (wake_hit) begin
                    n.st = pmsp_pkg::ST_BUCK;
                end
            end
            default: begin
                n.st  = pmsp_pkg::ST_OFF;
                n.tmr = '0;
            end
        endcase

        // Supply loss overrides the powered states
        if (r.st[8:1] != 8'h00) begin
            if (!r.vin_ok && r.st != pmsp_pkg::ST_OFF) begin
                n.st  = pmsp_pkg::ST_UVLO;
                n.tmr = '0;
            end else if (r.vp_seen && !r.flt[`PMSP_S_VP_UVF]) begin
                n.st  = pmsp_pkg::ST_BACK;
                n.tmr = TW'(T_BACK_CYC);
            end
        end

        if (n.st[11:9] != 3'h0 || n.st == pmsp_pkg::ST_OFF) begin
            n.vp_seen = 1'b0;
        end

        // Regulator enables follow the next state
        case (n.st)
            pmsp_pkg::ST_BUCK, pmsp_pkg::ST_VPW: n.rails = 5'b10000;
            pmsp_pkg::ST_SYSW:                   n.rails = 5'b11000;
            pmsp_pkg::ST_IOW:                    n.rails = 5'b11100;
            pmsp_pkg::ST_ANAW:                   n.rails = 5'b11110;
            pmsp_pkg::ST_CHK, pmsp_pkg::ST_RSTD,
            pmsp_pkg::ST_RUN:                    n.rails = 5'b11111;
            default:                             n.rails = 5'b00000;
        endcase

        n.mcu_run = (n.st == pmsp_pkg::ST_RUN);

        // Hibernate keeps the pump off
        if (n.st == pmsp_pkg::ST_HIB) begin
            n.pump = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_s) begin
        if (!rst_s) begin
            r        <= '0;
            r.st     <= pmsp_pkg::ST_OFF;
            r.wake   <= `PMSP_RST_WAKE;
            r.irq_en <= `PMSP_RST_IRQ_EN;
        end else begin
            r <= n;
        end
    end

    assign apb_rsp.pready            = 1'b1;
    assign apb_rsp.prdata            = r.prdata;
    assign apb_rsp.pslverr           = r.pslverr;
    assign rails                     = r.rails;
    assign mcu_rst_n                 = r.mcu_run;
    assign gate_drive_pump_en        = r.pump;
    assign monitoring_multiplexer_sel = r.mux;
    assign pack_thr_high             = r.wake[`PMSP_WAKE_PACK_HI];
    assign temp_irq                  = r.irq;

    // Sequencing and status checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_s);

    AST_BUCK_START: assert property (r.st == pmsp_pkg::ST_OFF && r.flt[0] |=>
        rails.high_voltage_step_down) else $error("converter not started");

    AST_SYS_AFTER_VP: assert property ($rose(rails.system_supply) |->
        $past(r.st) == pmsp_pkg::ST_VPW && $past(tmr_done)) else $error("system early");

    AST_IO_AFTER_PG: assert property ($rose(rails.io_supply) |->
        $past(r.flt[`PMSP_S_SYS_PG]) && $past(tmr_done)) else $error("io early");

    AST_ANA_AFTER_IO: assert property ($rose(rails.analog_supply) |->
        $past(r.st) == pmsp_pkg::ST_IOW && $past(tmr_done)) else $error("analog early");

    AST_CORE_LAST: assert property ($rose(rails.core_supply) |->
        rails.analog_supply && rails.io_supply && rails.system_supply)
        else $error("core out of order");

    AST_CHECK_HOLD: assert property (r.st == pmsp_pkg::ST_CHK && !go_ok |=>
        r.st == pmsp_pkg::ST_CHK || r.st[11:9] != 3'h0) else $error("check passed bad");

    AST_MCU_RELEASE: assert property ($rose(mcu_rst_n) |->
        $past(r.st) == pmsp_pkg::ST_RSTD && $past(tmr_done)) else $error("reset early");

    AST_UV_RESTART: assert property (r.st == pmsp_pkg::ST_UVLO && r.vin_ok |=>
        rails.high_voltage_step_down) else $error("no restart");

    AST_BACKOFF: assert property (r.st == pmsp_pkg::ST_BACK && !tmr_done |=>
        !rails.high_voltage_step_down) else $error("backoff broken");

    AST_VIN_HYST: assert property (!r.flt[`PMSP_S_VIN_UVF] |=> !r.vin_ok)
        else $error("hysteresis wrong");

    AST_HIB_OFF: assert property (r.st == pmsp_pkg::ST_HIB |->
        rails == 5'b00000 && !gate_drive_pump_en) else $error("rail on in hibernate");

    AST_PG_FAULT: assert property (r.st == pmsp_pkg::ST_RUN && !all_pg |=>
        !mcu_rst_n && r.stat[`PMSP_STAT_PGF]) else $error("pg fault missed");

    AST_HOLD_RESET: assert property (!go_ok |=> !mcu_rst_n)
        else $error("mcu out of reset");

    AST_IRQ_GATE: assert property (temp_irq |->
        |(r.stat[2:0] & r.irq_en)) else $error("irq not enabled");

    AST_FAULT_KEEP: assert property (r.stat[`PMSP_STAT_F155] &&
        stat_clr[`PMSP_STAT_F155] == 1'b0 |=> r.stat[`PMSP_STAT_F155])
        else $error("fault lost");

    AST_WAKE_START: assert property (r.st == pmsp_pkg::ST_HIB && wake_hit |=>
        rails.high_voltage_step_down) else $error("no wake");

    AST_WARN_FLAG: assert property (r.flt[`PMSP_S_T120] |=>
        r.stat[`PMSP_STAT_W120]) else $error("warning not flagged");

    AST_WARN_RUN: assert property (r.st == pmsp_pkg::ST_RUN && go_ok && r.vin_ok
        && r.flt[`PMSP_S_VP_UVF] && !hib_req |=> mcu_rst_n)
        else $error("warning reset mcu");

    AST_TEMP_FAULT: assert property (r.flt[`PMSP_S_T155] |=>
        !mcu_rst_n && r.stat[`PMSP_STAT_F155]) else $error("temp fault missed");

    COV_RUN: cover property ($rose(mcu_rst_n));

    COV_BACKOFF: cover property (r.st == pmsp_pkg::ST_BACK ##1 r.st == pmsp_pkg::ST_BUCK);

    COV_WAKE: cover property (r.st == pmsp_pkg::ST_HIB ##1 r.st == pmsp_pkg::ST_BUCK);

    COV_TEMP_FAULT: cover property ($rose(r.stat[`PMSP_STAT_F155]));

    COV_PG_FAULT: cover property ($rose(r.stat[`PMSP_STAT_PGF]));

endmodule : pmsp_top

// >>> pkg/pmsp_params.svh
`ifndef PMSP_PARAMS_SVH
`define PMSP_PARAMS_SVH

`define PMSP_CLK_MHZ      100
`define PMSP_T_VP_US      4000
`define PMSP_T_SYS_US     500
`define PMSP_T_IO_US      500
`define PMSP_T_ANA_US     1000
`define PMSP_T_CHK_US     500
`define PMSP_T_RST_US     11500
`define PMSP_T_BACK_US    350000
`define PMSP_T_VP_CYC     (`PMSP_T_VP_US * `PMSP_CLK_MHZ)
`define PMSP_T_SYS_CYC    (`PMSP_T_SYS_US * `PMSP_CLK_MHZ)
`define PMSP_T_IO_CYC     (`PMSP_T_IO_US * `PMSP_CLK_MHZ)
`define PMSP_T_ANA_CYC    (`PMSP_T_ANA_US * `PMSP_CLK_MHZ)
`define PMSP_T_CHK_CYC    (`PMSP_T_CHK_US * `PMSP_CLK_MHZ)
`define PMSP_T_RST_CYC    (`PMSP_T_RST_US * `PMSP_CLK_MHZ)
`define PMSP_T_BACK_CYC   (`PMSP_T_BACK_US * `PMSP_CLK_MHZ)
`define PMSP_TMR_W        26
`define PMSP_DEB_CYC      3'h4
`define PMSP_NS           15

`define PMSP_S_VIN_START  0
`define PMSP_S_VIN_UVR    1
`define PMSP_S_VIN_UVF    2
`define PMSP_S_VP_UVR     3
`define PMSP_S_VP_UVF     4
`define PMSP_S_SYS_PG     5
`define PMSP_S_IO_PG      6
`define PMSP_S_ANA_PG     7
`define PMSP_S_CORE_PG    8
`define PMSP_S_T120       9
`define PMSP_S_T140       10
`define PMSP_S_T155       11
`define PMSP_S_BUTTON     12
`define PMSP_S_PACK       13
`define PMSP_S_WAKE_TMR   14

`define PMSP_OFF_CTRL     8'h00
`define PMSP_OFF_WAKE     8'h04
`define PMSP_OFF_STAT     8'h08
`define PMSP_OFF_IRQ_EN   8'h0c
`define PMSP_OFF_STATE    8'h10

`define PMSP_CTRL_HIB     0
`define PMSP_CTRL_PUMP    1
`define PMSP_CTRL_MUX_LO  2
`define PMSP_CTRL_MUX_HI  4
`define PMSP_WAKE_BTN_EN  0
`define PMSP_WAKE_BTN_POL 1
`define PMSP_WAKE_PACK_EN 2
`define PMSP_WAKE_PACK_HI 3
`define PMSP_WAKE_TMR_EN  4
`define PMSP_STAT_W120    0
`define PMSP_STAT_W140    1
`define PMSP_STAT_F155    2
`define PMSP_STAT_PGF     3

`define PMSP_RST_WAKE     5'h00
`define PMSP_RST_IRQ_EN   3'h0

`endif

// >>> pkg/pmsp_pkg.sv
`include "pmsp_params.svh"
package pmsp_pkg;

    typedef enum logic [11:0] {
        ST_OFF  = 12'h001,
        ST_BUCK = 12'h002,
        ST_VPW  = 12'h004,
        ST_SYSW = 12'h008,
        ST_IOW  = 12'h010,
        ST_ANAW = 12'h020,
        ST_CHK  = 12'h040,
        ST_RSTD = 12'h080,
        ST_RUN  = 12'h100,
        ST_BACK = 12'h200,
        ST_UVLO = 12'h400,
        ST_HIB  = 12'h800
    } pmsp_state_t;

    typedef enum logic [2:0] {
        MUX_PACK_X002 = 3'h0,
        MUX_BAT_X002  = 3'h1,
        MUX_VIN_X002  = 3'h2,
        MUX_CORE      = 3'h3,
        MUX_ANA_X04   = 3'h4,
        MUX_IO_X04    = 3'h5,
        MUX_SYS_X04   = 3'h6,
        MUX_TEMP      = 3'h7
    } pmsp_mux_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pmsp_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } pmsp_apb_rsp_t;

    typedef struct packed {
        logic high_voltage_step_down;
        logic system_supply;
        logic io_supply;
        logic analog_supply;
        logic core_supply;
    } pmsp_rails_t;

    typedef struct packed {
        logic [`PMSP_NS-1:0]       s1;
        logic [`PMSP_NS-1:0]       s2;
        logic [`PMSP_NS-1:0]       flt;
        logic [`PMSP_NS-1:0][2:0]  dc;
        pmsp_state_t               st;
        logic [`PMSP_TMR_W-1:0]    tmr;
        logic                      vin_ok;
        logic                      vp_seen;
        logic                      pump;
        pmsp_mux_t                 mux;
        logic [4:0]                wake;
        logic [3:0]                stat;
        logic [2:0]                irq_en;
        logic [31:0]               prdata;
        logic                      pslverr;
        pmsp_rails_t               rails;
        logic                      mcu_run;
        logic                      irq;
    } pmsp_regs_t;

endpackage : pmsp_pkg

// >>> tb/pmsp_plant.sv
`timescale 1ns/10ps
module pmsp_plant (
    input  wire logic                  sys_clk,
    input  wire pmsp_pkg::pmsp_rails_t rails,
    input  wire logic [4:0]            fail,
    output      logic [5:0]            rail_sense
);
    // Enabled rail comes good 4 cycles later, collapses at once
    logic [4:0]      en;
    logic [4:0][3:0] dly;
    logic [4:0]      good;
    assign en = rails;
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 5; i++) begin
            dly[i] <= {dly[i][2:0], en[i]};
        end
    end
    assign good = en & ~fail & {dly[4][3], dly[3][3], dly[2][3], dly[1][3], dly[0][3]};
    assign rail_sense = {good[0], good[1], good[2], good[3], good[4], good[4]};
endmodule : pmsp_plant

// >>> tb/tb_pmsp_top.sv
`timescale 1ns/10ps
module tb_pmsp_top;
    localparam int TP = 20;
    logic                    sys_clk = 1'b0;
    logic                    rst_n = 1'b0;
    pmsp_pkg::pmsp_apb_req_t apb_req = '0;
    pmsp_pkg::pmsp_apb_rsp_t apb_rsp;
    pmsp_pkg::pmsp_rails_t   rails;
    pmsp_pkg::pmsp_mux_t     mux_sel;
    logic                    mcu_rst_n;
    logic                    pump;
    logic                    pack_thr_high;
    logic                    temp_irq;
    logic [14:0]             drv = '0;
    logic [4:0]              fail = '0;
    logic [5:0]              rail_sense;
    logic [14:0]             sense;
    logic [4:0]              en_obs;
    logic [6:0]              obs;
    logic [31:0]             rdat;
    logic                    rerr;
    int                      err_total = 0;
    int                      comparisons = 0;
    int                      n;
    assign sense = {drv[14:9], rail_sense, drv[2:0]};
    assign en_obs = rails;
    assign obs = {temp_irq, mcu_rst_n, en_obs};
    always #5 sys_clk = ~sys_clk;
    pmsp_top #(.T_VP_CYC(TP), .T_SYS_CYC(TP), .T_IO_CYC(TP), .T_ANA_CYC(TP),
        .T_CHK_CYC(TP), .T_RST_CYC(TP), .T_BACK_CYC(TP)) pmsp_top_i (
        .sys_clk                    (sys_clk),
        .rst_n                      (rst_n),
        .apb_req                    (apb_req),
        .apb_rsp                    (apb_rsp),
        .sense                      (sense),
        .rails                      (rails),
        .mcu_rst_n                  (mcu_rst_n),
        .gate_drive_pump_en         (pump),
        .monitoring_multiplexer_sel (mux_sel),
        .pack_thr_high              (pack_thr_high),
        .temp_irq                   (temp_irq)
    );
    pmsp_plant pmsp_plant_i (
        .sys_clk    (sys_clk),
        .rails      (rails),
        .fail       (fail),
        .rail_sense (rail_sense)
    );
    task automatic complete_run;
        $display("Counts: %0d compares, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic bad(input string m);
        err_total++;
        $display("BAD %0t %s", $time, m);
    endtask : bad
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) bad(m);
    endtask : check_val
    task automatic check_rng(input int k, input int lo, input int hi, input string m);
        comparisons++;
        if (k < lo || k > hi) bad(m);
    endtask : check_rng
    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : idle
    task automatic set_in(input int b, input logic v);
        @(posedge sys_clk);
        drv[b] <= v;
    endtask : set_in
    task automatic wait_obs(input int b, input logic v, input int lim, output int k);
        k = 0;
        while (obs[b] !== v && k < lim) begin
            @(posedge sys_clk);
            k++;
        end
        if (obs[b] !== v) begin
            bad("wait timed out");
            complete_run();
        end
    endtask : wait_obs
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge sys_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (apb_rsp.pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad("apb timed out");
            complete_run();
        end
        rdat = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req <= '0;
        #1;
    endtask : apb_xfer
    task automatic power_up;
        wait_obs(3, 1'b1, 100, n);
        check_rng(n, TP, TP + 16, "system delay");
        wait_obs(2, 1'b1, 100, n);
        check_rng(n, TP, TP + 16, "io delay");
        wait_obs(1, 1'b1, 100, n);
        check_rng(n, TP - 1, TP + 3, "analog delay");
        wait_obs(0, 1'b1, 100, n);
        check_rng(n, TP - 1, TP + 3, "core delay");
        wait_obs(5, 1'b1, 200, n);
        check_rng(n, 2 * TP - 1, 2 * TP + 5, "reset release");
    endtask : power_up
    task automatic t_reset;
        idle(20);
        check_val(obs, 7'h00, "outputs after reset");
        apb_xfer(1'b0, 8'h04, 32'h0);
        check_val(rdat, 32'h0, "wake reset");
        apb_xfer(1'b0, 8'h0c, 32'h0);
        check_val(rdat, 32'h0, "irq enable reset");
        apb_xfer(1'b0, 8'h20, 32'h0);
        check_val(rerr, 1'b1, "unmapped error");
        check_val(rdat, 32'h0, "unmapped data");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_powerup;
        @(posedge sys_clk);
        drv[2:0] <= 3'h7;
        wait_obs(4, 1'b1, 30, n);
        check_rng(n, 6, 12, "converter start");
        power_up();
        $display("t_powerup done");
    endtask : t_powerup
    task automatic t_mux;
        for (int i = 0; i < 8; i++) begin
            apb_xfer(1'b1, 8'h00, 32'(i * 4 + 2));
            check_val(32'(mux_sel), 32'(i), "mux select");
            check_val(pump, 1'b1, "pump on");
        end
        apb_xfer(1'b1, 8'h00, 32'h0);
        check_val(pump, 1'b0, "pump off");
        $display("t_mux done");
    endtask : t_mux
    task automatic t_temp;
        set_in(9, 1'b1);
        set_in(10, 1'b1);
        idle(12);
        check_val({temp_irq, mcu_rst_n}, 2'b01, "warning masked");
        apb_xfer(1'b0, 8'h08, 32'h0);
        check_val(rdat[1:0], 2'h3, "warning status");
        apb_xfer(1'b1, 8'h0c, 32'h1);
        idle(3);
        check_val(temp_irq, 1'b1, "warning irq");
        set_in(9, 1'b0);
        set_in(10, 1'b0);
        idle(10);
        apb_xfer(1'b1, 8'h08, 32'h3);
        idle(3);
        check_val(temp_irq, 1'b0, "irq cleared");
        set_in(11, 1'b1);
        wait_obs(5, 1'b0, 15, n);
        set_in(11, 1'b0);
        wait_obs(5, 1'b1, 3 * TP + 20, n);
        apb_xfer(1'b0, 8'h08, 32'h0);
        check_val(rdat[3:0], 4'h4, "fault kept");
        apb_xfer(1'b1, 8'h08, 32'hf);
        apb_xfer(1'b1, 8'h0c, 32'h0);
        $display("t_temp done");
    endtask : t_temp
    task automatic t_pgloss;
        @(posedge sys_clk);
        fail[3] <= 1'b1;
        wait_obs(5, 1'b0, 15, n);
        apb_xfer(1'b0, 8'h08, 32'h0);
        check_val(rdat[3], 1'b1, "supply fault flag");
        @(posedge sys_clk);
        fail[3] <= 1'b0;
        wait_obs(5, 1'b1, 3 * TP, n);
        check_rng(n, TP, TP + 14, "reset hold");
        apb_xfer(1'b1, 8'h08, 32'hf);
        $display("t_pgloss done");
    endtask : t_pgloss
    task automatic t_uvlo;
        set_in(1, 1'b0);
        idle(15);
        check_val({mcu_rst_n, rails.high_voltage_step_down}, 2'b11, "hysteresis on");
        set_in(2, 1'b0);
        wait_obs(4, 1'b0, 20, n);
        idle(1);
        check_val(en_obs, 5'h00, "uvlo rails");
        set_in(2, 1'b1);
        idle(15);
        check_val(en_obs, 5'h00, "hysteresis off");
        set_in(1, 1'b1);
        wait_obs(4, 1'b1, 20, n);
        check_rng(n, 1, 12, "uvlo restart");
        power_up();
        $display("t_uvlo done");
    endtask : t_uvlo
    task automatic t_back;
        @(posedge sys_clk);
        fail[4] <= 1'b1;
        wait_obs(4, 1'b0, 20, n);
        idle(1);
        check_val(en_obs, 5'h00, "backoff rails");
        fail[4] <= 1'b0;
        wait_obs(4, 1'b1, 2 * TP, n);
        check_rng(n, TP - 2, TP + 3, "backoff time");
        power_up();
        $display("t_back done");
    endtask : t_back
    task automatic t_hib;
        logic [4:0] wk [3];
        int         src [3];
        wk = '{5'h03, 5'h0c, 5'h10};
        src = '{12, 13, 14};
        for (int i = 0; i < 3; i++) begin
            apb_xfer(1'b1, 8'h04, 32'(wk[i]));
            check_val(pack_thr_high, wk[i][3], "pack threshold");
            apb_xfer(1'b1, 8'h00, 32'h3);
            wait_obs(4, 1'b0, 5, n);
            idle(1);
            check_val({pump, en_obs}, 6'h00, "hibernate off");
            idle(20);
            check_val(en_obs, 5'h00, "stays asleep");
            set_in(src[i], 1'b1);
            wait_obs(4, 1'b1, 15, n);
            check_rng(n, 1, 12, "wake source");
            set_in(src[i], 1'b0);
            power_up();
        end
        $display("t_hib done");
    endtask : t_hib
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        idle(3);
        t_reset();
        t_powerup();
        t_mux();
        t_temp();
        t_pgloss();
        t_uvlo();
        t_back();
        t_hib();
        complete_run();
    end
endmodule : tb_pmsp_top
